// ===== bench/erff_far_model.sv
// Far-side sinks: framer egress port and MAC transmit port
`timescale 1ns/10ps
module erff_far_model (
	input  wire logic                        sys_clk,
	input  wire logic                        hold,
	input  wire logic                        gfp_tx_rts,
	output logic                             gfp_tx_rtr,
	input  wire logic [erff_pkg::DATA_W-1:0] gfp_tx_data,
	input  wire logic [erff_pkg::CNT_W-1:0]  gfp_tx_bytes,
	input  wire logic                        gfp_tx_last,
	input  wire logic                        mac_tx_rts,
	output logic                             mac_tx_rtr,
	input  wire logic [erff_pkg::BYTE_W-1:0] mac_tx_data,
	input  wire logic                        mac_tx_sof,
	input  wire logic                        mac_tx_last
);
	import erff_pkg::*;
	logic [WORD_W-1:0] tx_q[$];
	logic [9:0]        rx_q[$];
	logic [1:0]        ph = 2'h0;
	// Acknowledges come in bursts with gaps, framer can be held off entirely
	always @(negedge sys_clk) begin
		ph <= ph + 2'h1;
		gfp_tx_rtr <= !hold && ph[1];
		mac_tx_rtr <= ph != 2'h0;
	end
	// Unused lanes of a short word are not kept
	always @(posedge sys_clk) begin
		if (gfp_tx_rts && gfp_tx_rtr)
			tx_q.push_back({gfp_tx_last, gfp_tx_bytes, gfp_tx_data & ~(32'hFFFFFFFF << (8 * gfp_tx_bytes + 8))});
		if (mac_tx_rts && mac_tx_rtr)
			rx_q.push_back({mac_tx_sof, mac_tx_last, mac_tx_data});
	end
endmodule

// ===== bench/erff_top_tb_top.sv
// Self-checking bench for the Ethernet/radio frame buffer
`timescale 1ns/10ps
module erff_top_tb_top;
	import erff_pkg::*;
	logic              sys_clk = 1'h0, nrst = 1'h0, full_duplex = 1'h1, col_excess = 1'h0, hold = 1'h0;
	logic              mac_rx_rts = 1'h0, mac_rx_valid = 1'h0, mac_rx_sof = 1'h0, mac_rx_last = 1'h0;
	logic              mac_rx_crc_bad = 1'h0, mac_rx_abort = 1'h0, mac_rx_rtr;
	logic [BYTE_W-1:0] mac_rx_data = 8'h00, mac_tx_data;
	logic              gfp_rx_rts = 1'h0, gfp_rx_valid = 1'h0, gfp_rx_last = 1'h0, gfp_rx_err = 1'h0;
	logic [DATA_W-1:0] gfp_rx_data = 32'h0, gfp_tx_data;
	logic [CNT_W-1:0]  gfp_rx_bytes = 2'h0, gfp_tx_bytes;
	logic              gfp_tx_rts, gfp_tx_rtr, gfp_tx_last, gfp_rx_rtr, gfp_rx_stop;
	logic              mac_tx_rts, mac_tx_rtr, mac_tx_sof, mac_tx_last;
	int                err_total = 0, samples_checked = 0, stops = 0;
	logic [WORD_W-1:0] exp_tx[$];
	logic [9:0]        exp_rx[$];

	erff_top #(.DEPTH(64), .MARGIN(4)) u_erff_top (
		.sys_clk        (sys_clk),
		.nrst           (nrst),
		.full_duplex    (full_duplex),
		.col_excess     (col_excess),
		.mac_rx_rts     (mac_rx_rts),
		.mac_rx_rtr     (mac_rx_rtr),
		.mac_rx_valid   (mac_rx_valid),
		.mac_rx_data    (mac_rx_data),
		.mac_rx_sof     (mac_rx_sof),
		.mac_rx_last    (mac_rx_last),
		.mac_rx_crc_bad (mac_rx_crc_bad),
		.mac_rx_abort   (mac_rx_abort),
		.gfp_tx_rts     (gfp_tx_rts),
		.gfp_tx_rtr     (gfp_tx_rtr),
		.gfp_tx_data    (gfp_tx_data),
		.gfp_tx_bytes   (gfp_tx_bytes),
		.gfp_tx_last    (gfp_tx_last),
		.gfp_rx_rts     (gfp_rx_rts),
		.gfp_rx_rtr     (gfp_rx_rtr),
		.gfp_rx_valid   (gfp_rx_valid),
		.gfp_rx_data    (gfp_rx_data),
		.gfp_rx_bytes   (gfp_rx_bytes),
		.gfp_rx_last    (gfp_rx_last),
		.gfp_rx_err     (gfp_rx_err),
		.gfp_rx_stop    (gfp_rx_stop),
		.mac_tx_rts     (mac_tx_rts),
		.mac_tx_rtr     (mac_tx_rtr),
		.mac_tx_data    (mac_tx_data),
		.mac_tx_sof     (mac_tx_sof),
		.mac_tx_last    (mac_tx_last)
	);
	erff_far_model u_erff_far_model (
		.sys_clk      (sys_clk),
		.hold         (hold),
		.gfp_tx_rts   (gfp_tx_rts),
		.gfp_tx_rtr   (gfp_tx_rtr),
		.gfp_tx_data  (gfp_tx_data),
		.gfp_tx_bytes (gfp_tx_bytes),
		.gfp_tx_last  (gfp_tx_last),
		.mac_tx_rts   (mac_tx_rts),
		.mac_tx_rtr   (mac_tx_rtr),
		.mac_tx_data  (mac_tx_data),
		.mac_tx_sof   (mac_tx_sof),
		.mac_tx_last  (mac_tx_last)
	);

	initial forever #2.5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (gfp_rx_stop === 1'h1) stops++;

	task automatic chk(string what, logic [WORD_W-1:0] e, logic [WORD_W-1:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic logic [WORD_W-1:0] eword(int i, int n, int s);
		logic [WORD_W-1:0] r;
		int k;
		r = 35'h0;
		for (k = 0; k < 4 && i + k < n; k++) r[8*k +: 8] = 8'(s + i + k);
		r[WORD_W-1:DATA_W] = {i + 4 >= n, 2'(k - 1)};
		return r;
	endfunction

	task automatic flush;
		int i;
		for (i = 0; i < 3000; i++) begin
			if (u_erff_far_model.tx_q.size() >= exp_tx.size() && u_erff_far_model.rx_q.size() >= exp_rx.size()) break;
			@(negedge sys_clk);
		end
		repeat (20) @(negedge sys_clk);
		chk("egress count", 35'(exp_tx.size()), 35'(u_erff_far_model.tx_q.size()));
		chk("ingress count", 35'(exp_rx.size()), 35'(u_erff_far_model.rx_q.size()));
		foreach (exp_tx[k]) if (k < u_erff_far_model.tx_q.size()) chk("egress word", exp_tx[k], u_erff_far_model.tx_q[k]);
		foreach (exp_rx[k]) if (k < u_erff_far_model.rx_q.size()) chk("ingress byte", exp_rx[k], u_erff_far_model.rx_q[k]);
		exp_tx.delete();
		exp_rx.delete();
		u_erff_far_model.tx_q.delete();
		u_erff_far_model.rx_q.delete();
	endtask

	// Kind 1 aborts, kind 2 raises excessive collision, both at byte at
	task automatic mac_frame(int n, int s, int kind = 0, int at = 0, logic bad = 1'h0);
		int i, w;
		for (i = 0; i < n; i++) begin
			@(negedge sys_clk);
			{mac_rx_rts, mac_rx_valid, mac_rx_sof, mac_rx_last} = {2'h3, i == 0, i == n - 1};
			{mac_rx_crc_bad, mac_rx_abort, col_excess} = {bad && i == n - 1, kind == 1 && i == at, kind == 2 && i == at};
			mac_rx_data = 8'(s + i);
			for (w = 0; w < 200 && mac_rx_rtr !== 1'h1; w++) @(negedge sys_clk);
		end
		@(negedge sys_clk);
		{mac_rx_rts, mac_rx_valid, mac_rx_sof, mac_rx_last, mac_rx_crc_bad, mac_rx_abort, col_excess} = 7'h0;
		if (!bad && (kind == 0 || (kind == 2 && full_duplex))) for (i = 0; i < n; i += 4) exp_tx.push_back(eword(i, n, s));
	endtask

	task automatic gfp_frame(int n, int s, int err_at = -1);
		int i, w;
		for (i = 0; i < n; i += 4) begin
			if (i == 32) begin
				@(negedge sys_clk);
				gfp_rx_valid = 1'h0;
				repeat (30) @(negedge sys_clk);
				chk("held bytes", 35'h0, 35'(u_erff_far_model.rx_q.size()));
			end
			@(negedge sys_clk);
			{gfp_rx_rts, gfp_rx_valid, gfp_rx_err} = {2'h3, i / 4 == err_at};
			{gfp_rx_last, gfp_rx_bytes, gfp_rx_data} = eword(i, n, s);
			for (w = 0; w < 200 && gfp_rx_rtr !== 1'h1; w++) @(negedge sys_clk);
			if (i / 4 == err_at) break;
		end
		@(negedge sys_clk);
		{gfp_rx_rts, gfp_rx_valid, gfp_rx_err, gfp_rx_last} = 4'h0;
		if (err_at < 0 && n >= 64) for (i = 0; i < n; i++) exp_rx.push_back({i == 0, i == n - 1, 8'(s + i)});
		flush;
	endtask

	task automatic t_egress;
		mac_frame(8, 8'h10);
		mac_frame(5, 8'h40);
		flush;
		$display("test egress done, mismatches %0d", err_total);
	endtask

	task automatic t_drop;
		mac_frame(12, 8'h20, 1, 5);
		mac_frame(4, 8'h30);
		mac_frame(8, 8'h50, 0, 0, 1'h1);
		full_duplex = 1'h0;
		mac_frame(8, 8'h60, 2, 3);
		mac_frame(6, 8'h70);
		full_duplex = 1'h1;
		mac_frame(8, 8'h80, 2, 3);
		flush;
		$display("test drop done, mismatches %0d", err_total);
	endtask

	task automatic t_full;
		hold = 1'h1;
		mac_frame(240, 8'h11);
		mac_frame(4, 8'h99);
		@(negedge sys_clk);
		mac_rx_rts = 1'h1;
		repeat (3) @(negedge sys_clk);
		chk("rtr at mark", 35'h0, 35'(mac_rx_rtr));
		hold = 1'h0;
		flush;
		chk("rtr after drain", 35'h1, 35'(mac_rx_rtr));
		mac_rx_rts = 1'h0;
		$display("test full done, mismatches %0d", err_total);
	endtask

	task automatic t_ingress;
		gfp_frame(64, 8'h01);
		gfp_frame(60, 8'h11);
		gfp_frame(65, 8'h21);
		stops = 0;
		gfp_frame(64, 8'h31, 2);
		chk("stop pulses", 35'h1, 35'(stops));
		gfp_frame(64, 8'h41);
		$display("test ingress done, mismatches %0d", err_total);
	endtask

	initial begin
		repeat (6) @(negedge sys_clk);
		nrst = 1'h1;
		t_egress;
		t_drop;
		t_full;
		t_ingress;
		results;
	end

	initial begin
		#200000;
		err_total++;
		results;
	end
endmodule

// ===== rtl/erff_pkg.sv
// Constants and types shared by the Ethernet/radio frame buffer
// Notes on behaviour
// - MAC-side bytes are taken one per transfer and stored in arrival order.
// - Stored egress data is read in order and handed to the framer as 4-byte words.
// - MAC raises ready-to-send; buffer answers ready-to-receive before any byte moves.
// - Framer-side output exchanges ready signals; a word moves only when the framer acknowledges.
// - MAC abort stops the current frame and discards what was stored of it.
// - Framer-side reading runs while MAC-side writing continues.
// - Each direction stores data in a synchronous two-port memory, separate write and read ports.
// - Ingress takes 4-byte words in order and passes bytes to the MAC singly.
// - Invalid framer data makes the buffer tell the framer to stop and restart.
// - Watermarks on fill level throttle both paths to keep thresholds in limits.
// - On under-run a partial frame is held until its last word arrives.
// - Ingress frames shorter than 64 bytes are errors and are dropped.
// - Half duplex: excessive collisions halt transfer and remove the corrupted data.
// - Full duplex: collision sensing is off and never interrupts data.
// - Frame start and end from the MAC receive stream delimit stored frames.
// - Frames sent toward the MAC carry start and end delimiters.
// - Frames failing the MAC checksum are invalid and discarded.
// - Egress words group consecutive characters for the framer's block coding.
// - Framer header check results (16-bit CRC) arrive as the invalid-data flag.
// - Frame end and byte count per word let the framer fill fixed-length frames.
// - Decoded 8-bit characters from the framer are stored and passed on.
// - Half and full duplex at 10 and 100 Mb/s are both supported.
// - Depth absorbs 1000 Mb/s bursts while the radio side drains at 150 Mb/s.
package erff_pkg;
	localparam int BYTE_W          = 8;
	localparam int LANES           = 4;
	localparam int DATA_W          = BYTE_W * LANES;
	localparam int CNT_W           = 2;
	localparam int WORD_W          = DATA_W + CNT_W + 1;
	localparam int CNT_LSB         = DATA_W;
	localparam int LAST_BIT        = DATA_W + CNT_W;
	localparam int DEF_DEPTH       = 512;
	localparam int DEF_MARGIN      = 8;
	localparam int LEN_W           = 16;
	localparam logic [LEN_W-1:0] MIN_FRAME_BYTES = 16'h0040;
	localparam logic [CNT_W-1:0] LANE_FIRST      = 2'h0;
	localparam logic [CNT_W-1:0] LANE_LAST       = 2'h3;
	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_SEND} erff_rd_state_type;
endpackage

// ===== rtl/erff_sram.sv
// Synchronous two-port memory, one write port and one registered read port
`timescale 1ns/10ps
module erff_sram #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// ===== rtl/erff_top.sv
// Egress and ingress frame buffers between the MAC and the framer
`timescale 1ns/10ps
module erff_top #(
	parameter int DEPTH  = erff_pkg::DEF_DEPTH,
	parameter int MARGIN = erff_pkg::DEF_MARGIN
) (
	input  wire logic                       sys_clk,
	input  wire logic                       nrst,
	input  wire logic                       full_duplex,
	input  wire logic                       col_excess,
	input  wire logic                       mac_rx_rts,
	output logic                            mac_rx_rtr,
	input  wire logic                       mac_rx_valid,
	input  wire logic [erff_pkg::BYTE_W-1:0] mac_rx_data,
	input  wire logic                       mac_rx_sof,
	input  wire logic                       mac_rx_last,
	input  wire logic                       mac_rx_crc_bad,
	input  wire logic                       mac_rx_abort,
	output logic                            gfp_tx_rts,
	input  wire logic                       gfp_tx_rtr,
	output logic [erff_pkg::DATA_W-1:0]     gfp_tx_data,
	output logic [erff_pkg::CNT_W-1:0]      gfp_tx_bytes,
	output logic                            gfp_tx_last,
	input  wire logic                       gfp_rx_rts,
	output logic                            gfp_rx_rtr,
	input  wire logic                       gfp_rx_valid,
	input  wire logic [erff_pkg::DATA_W-1:0] gfp_rx_data,
	input  wire logic [erff_pkg::CNT_W-1:0] gfp_rx_bytes,
	input  wire logic                       gfp_rx_last,
	input  wire logic                       gfp_rx_err,
	output logic                            gfp_rx_stop,
	output logic                            mac_tx_rts,
	input  wire logic                       mac_tx_rtr,
	output logic [erff_pkg::BYTE_W-1:0]     mac_tx_data,
	output logic                            mac_tx_sof,
	output logic                            mac_tx_last
);
	import erff_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam logic [PW-1:0] FULL_LVL = PW'(DEPTH);
	localparam logic [PW-1:0] HI_LVL   = PW'(DEPTH - MARGIN);

	// Egress path: MAC bytes to framer words
	logic [PW-1:0]     eg_wr;
	logic [PW-1:0]     eg_commit;
	logic [PW-1:0]     eg_rd;
	logic [PW-1:0]     eg_fill;
	logic              eg_full;
	logic              eg_hi;
	logic [CNT_W-1:0]  eg_idx;
	logic [CNT_W-1:0]  eg_lane;
	logic [DATA_W-1:0] eg_pack;
	logic [DATA_W-1:0] eg_word_next;
	logic              eg_drop;
	logic              eg_live;
	logic              eg_take;
	logic              eg_kill;
	logic              eg_done;
	logic              eg_ovf;
	logic              eg_bad_end;
	logic              eg_we;
	logic              eg_issue;
	logic              eg_rd_pend;
	logic [WORD_W-1:0] eg_rdata;

	assign eg_fill    = eg_wr - eg_rd;
	assign eg_full    = eg_fill == FULL_LVL;
	assign eg_hi      = eg_fill >= HI_LVL;
	assign eg_take    = mac_rx_rtr && mac_rx_valid;
	assign eg_kill    = mac_rx_abort || (col_excess && !full_duplex);
	assign eg_live    = !eg_drop || mac_rx_sof;
	assign eg_lane    = mac_rx_sof ? LANE_FIRST : eg_idx;
	assign eg_done    = eg_take && eg_live && (eg_lane == LANE_LAST || mac_rx_last);
	assign eg_ovf     = eg_done && eg_full && !eg_kill;
	assign eg_bad_end = eg_done && mac_rx_last && mac_rx_crc_bad;
	assign eg_we      = eg_done && !eg_full && !eg_kill && !eg_bad_end;
	assign eg_issue   = !gfp_tx_rts && !eg_rd_pend && (eg_commit != eg_rd);

	always_comb begin
		eg_word_next = eg_pack;
		eg_word_next[{eg_lane, 3'b000} +: BYTE_W] = mac_rx_data;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mac_rx_rtr <= 1'b0;
		end else begin
			mac_rx_rtr <= mac_rx_rts && !eg_hi;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			eg_idx  <= LANE_FIRST;
			eg_pack <= '0;
		end else if (eg_kill) begin
			eg_idx  <= LANE_FIRST;
		end else if (eg_take && eg_live) begin
			eg_pack <= eg_word_next;
			eg_idx  <= mac_rx_last ? LANE_FIRST : eg_lane + 2'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			eg_drop <= 1'b0;
		end else if (eg_kill || eg_ovf) begin
			eg_drop <= 1'b1;
		end else if (eg_take && mac_rx_sof) begin
			eg_drop <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			eg_wr     <= '0;
			eg_commit <= '0;
		end else if (eg_kill || eg_ovf || eg_bad_end) begin
			eg_wr <= eg_commit;
		end else if (eg_we) begin
			eg_wr <= eg_wr + 1'b1;
			if (mac_rx_last) begin
				eg_commit <= eg_wr + 1'b1;
			end
		end
	end

	erff_sram #(
		.WIDTH (WORD_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_eg_mem (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.wr_en   (eg_we),
		.wr_addr (eg_wr[AW-1:0]),
		.wr_data ({mac_rx_last, eg_lane, eg_word_next}),
		.rd_en   (eg_issue),
		.rd_addr (eg_rd[AW-1:0]),
		.rd_data (eg_rdata)
	);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			eg_rd        <= '0;
			eg_rd_pend   <= 1'b0;
			gfp_tx_rts   <= 1'b0;
			gfp_tx_data  <= '0;
			gfp_tx_bytes <= '0;
			gfp_tx_last  <= 1'b0;
		end else begin
			if (eg_issue) begin
				eg_rd      <= eg_rd + 1'b1;
				eg_rd_pend <= 1'b1;
			end else if (eg_rd_pend) begin
				eg_rd_pend   <= 1'b0;
				gfp_tx_rts   <= 1'b1;
				gfp_tx_data  <= eg_rdata[DATA_W-1:0];
				gfp_tx_bytes <= eg_rdata[CNT_LSB +: CNT_W];
				gfp_tx_last  <= eg_rdata[LAST_BIT];
			end else if (gfp_tx_rts && gfp_tx_rtr) begin
				gfp_tx_rts <= 1'b0;
			end
		end
	end

	// Ingress path: framer words to MAC bytes
	logic [PW-1:0]     in_wr;
	logic [PW-1:0]     in_commit;
	logic [PW-1:0]     in_rd;
	logic [PW-1:0]     in_fill;
	logic              in_full;
	logic              in_hi;
	logic [LEN_W-1:0]  in_len;
	logic [LEN_W-1:0]  in_len_next;
	logic              in_drop;
	logic              in_acc;
	logic              in_err;
	logic              in_short;
	logic              in_ovf;
	logic              in_we;
	logic              in_issue;
	logic [WORD_W-1:0] in_rdata;
	erff_rd_state_type in_state;
	logic [DATA_W-1:0] in_word;
	logic [CNT_W-1:0]  in_cnt;
	logic [CNT_W-1:0]  in_idx;
	logic [CNT_W-1:0]  in_idx_nx;
	logic              in_wlast;
	logic              in_sof_pend;

	assign in_fill     = in_wr - in_rd;
	assign in_full     = in_fill == FULL_LVL;
	assign in_hi       = in_fill >= HI_LVL;
	assign in_acc      = gfp_rx_rtr && gfp_rx_valid && !in_drop;
	assign in_len_next = in_len + LEN_W'(gfp_rx_bytes) + 16'h0001;
	assign in_err      = in_acc && gfp_rx_err;
	assign in_short    = in_acc && !gfp_rx_err && gfp_rx_last && in_len_next < MIN_FRAME_BYTES;
	assign in_ovf      = in_acc && !gfp_rx_err && in_full;
	assign in_we       = in_acc && !gfp_rx_err && !in_full && !in_short;
	assign in_issue    = in_state == RD_IDLE && in_commit != in_rd;
	assign in_idx_nx   = in_idx + 2'h1;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			gfp_rx_rtr  <= 1'b0;
			gfp_rx_stop <= 1'b0;
		end else begin
			gfp_rx_rtr  <= gfp_rx_rts && !in_hi;
			gfp_rx_stop <= in_err;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			in_drop <= 1'b0;
		end else if (in_ovf && !gfp_rx_last) begin
			in_drop <= 1'b1;
		end else if (gfp_rx_rtr && gfp_rx_valid && gfp_rx_last) begin
			in_drop <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			in_len <= '0;
		end else if (in_err || in_ovf || (in_acc && gfp_rx_last)) begin
			in_len <= '0;
		end else if (in_acc) begin
			in_len <= in_len_next;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			in_wr     <= '0;
			in_commit <= '0;
		end else if (in_err || in_short || in_ovf) begin
			in_wr <= in_commit;
		end else if (in_we) begin
			in_wr <= in_wr + 1'b1;
			if (gfp_rx_last) begin
				in_commit <= in_wr + 1'b1;
			end
		end
	end

	erff_sram #(
		.WIDTH (WORD_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_in_mem (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.wr_en   (in_we),
		.wr_addr (in_wr[AW-1:0]),
		.wr_data ({gfp_rx_last, gfp_rx_bytes, gfp_rx_data}),
		.rd_en   (in_issue),
		.rd_addr (in_rd[AW-1:0]),
		.rd_data (in_rdata)
	);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			in_state    <= RD_IDLE;
			in_rd       <= '0;
			in_word     <= '0;
			in_cnt      <= '0;
			in_idx      <= '0;
			in_wlast    <= 1'b0;
			in_sof_pend <= 1'b1;
			mac_tx_rts  <= 1'b0;
			mac_tx_data <= '0;
			mac_tx_sof  <= 1'b0;
			mac_tx_last <= 1'b0;
		end else begin
			unique case (in_state)
				RD_IDLE: begin
					if (in_issue) begin
						in_rd    <= in_rd + 1'b1;
						in_state <= RD_WAIT;
					end
				end
				RD_WAIT: begin
					in_word     <= in_rdata[DATA_W-1:0];
					in_cnt      <= in_rdata[CNT_LSB +: CNT_W];
					in_wlast    <= in_rdata[LAST_BIT];
					in_idx      <= LANE_FIRST;
					mac_tx_rts  <= 1'b1;
					mac_tx_data <= in_rdata[BYTE_W-1:0];
					mac_tx_sof  <= in_sof_pend;
					mac_tx_last <= in_rdata[LAST_BIT] && in_rdata[CNT_LSB +: CNT_W] == LANE_FIRST;
					in_state    <= RD_SEND;
				end
				RD_SEND: begin
					if (mac_tx_rtr) begin
						in_sof_pend <= mac_tx_last;
						mac_tx_sof  <= 1'b0;
						if (in_idx == in_cnt) begin
							mac_tx_rts  <= 1'b0;
							mac_tx_last <= 1'b0;
							in_state    <= RD_IDLE;
						end else begin
							in_idx      <= in_idx_nx;
							mac_tx_data <= in_word[{in_idx_nx, 3'b000} +: BYTE_W];
							mac_tx_last <= in_wlast && in_idx_nx == in_cnt;
						end
					end
				end
				default: in_state <= RD_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_rtr_after_rts: assert property (mac_rx_rtr |-> $past(mac_rx_rts))
		else $error("ready-to-receive without ready-to-send");
	a_rtr_watermark: assert property ($past(eg_hi) |-> !mac_rx_rtr)
		else $error("egress ready while above watermark");
	a_lane_order: assert property (eg_take && eg_live && !eg_kill && !mac_rx_last |=> eg_idx == $past(eg_lane) + 2'h1)
		else $error("egress byte lane out of order");
	a_abort_rewind: assert property (mac_rx_abort |=> eg_wr == eg_commit && eg_drop)
		else $error("abort did not discard frame");
	a_col_halt: assert property (!full_duplex && col_excess |=> eg_wr == eg_commit)
		else $error("half duplex collision not halted");
	a_fd_nocol: assert property (full_duplex && !mac_rx_abort && !eg_drop && !eg_ovf |=> !eg_drop)
		else $error("full duplex frame interrupted");
	a_tx_word_hold: assert property (gfp_tx_rts && !gfp_tx_rtr |=> gfp_tx_rts && $stable(gfp_tx_data))
		else $error("framer word changed before acknowledge");
	a_stop_pulse: assert property (in_err |=> gfp_rx_stop ##1 (!gfp_rx_stop || $past(in_err)))
		else $error("stop not signalled to framer");
	a_short_drop: assert property (in_short |=> in_wr == in_commit && $stable(in_commit))
		else $error("short frame kept");
	a_underrun_hold: assert property (in_state == RD_IDLE && in_commit == in_rd |=> (!mac_tx_rts)[*2])
		else $error("bytes released without committed frame");
	a_mac_byte_hold: assert property (mac_tx_rts && !mac_tx_rtr |=> mac_tx_rts && $stable(mac_tx_data))
		else $error("MAC byte changed before taken");

	c_concurrent: cover property (eg_we && eg_issue);
	c_eg_frame: cover property (gfp_tx_rts && gfp_tx_rtr && gfp_tx_last);
	c_in_frame: cover property (mac_tx_rts && mac_tx_rtr && mac_tx_last);
	c_short: cover property (in_short);
endmodule
